// [fault_supervisor_reconnect.sv]
// fault supervisor with reconnect timers and modbus holding-register access
// assumes fault conditions and their data arrive synchronous to clk
`timescale 1ns/100ps
`include "fault_supervisor_params.svh"
module fault_supervisor_reconnect #(
  parameter int unsigned TICK_CYCLES = `FS_CLK_HZ * `FS_TICK_S
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset,
  // fault detection
  input  wire logic [`FS_NUM_FAULTS-1:0]         fault_cond,
  input  wire fault_supervisor_pkg::severity_e   fault_sev [`FS_NUM_FAULTS],
  input  wire fault_supervisor_pkg::fault_data_s fault_data [`FS_NUM_FAULTS],
  input  wire logic [31:0]                       timestamp,
  // operating mode
  input  wire logic                              manual_mode,
  input  wire logic                              user_start,
  input  wire logic                              service_reset,
  // holding register access
  input  wire fault_supervisor_pkg::reg_req_s    reg_req,
  output logic [15:0]                            reg_rdata,
  // converter control
  output logic                                   power_converter_unit_run
);

  localparam int NF = `FS_NUM_FAULTS;

  logic [NF-1:0]        cond_prev_reg;
  logic [NF-1:0]        active_reg;
  logic [NF-1:0]        occurred_reg;
  logic [15:0]          count_reg   [NF];
  logic [15:0]          limit_reg   [NF];
  logic [15:0]          value_reg   [NF];
  logic [31:0]          time_reg    [NF];
  logic [5:0]           select_reg;
  logic [15:0]          tset_reg    [3];
  logic [15:0]          tstat_reg   [3];
  logic [2:0]           tbusy_reg;
  logic [31:0]          presc_reg;
  logic                 tick;
  logic                 lock_reg;
  logic                 run_reg;
  logic                 clear_hist;
  logic [NF-1:0]        rise;
  logic [NF-1:0]        fall;
  logic [NF-1:0]        logged;
  logic [2:0]           abort_hit;
  logic [2:0]           abort_cond;
  logic                 lock_hit;

  assign clear_hist = reg_req.wr && reg_req.addr == `FS_REG_CLEAR;
  assign rise       = fault_cond & ~cond_prev_reg;
  assign fall       = ~fault_cond & cond_prev_reg;

  // classify every newly detected fault; hits of each class are OR-combined so every class takes effect
  always_comb begin
    abort_hit  = 3'b000;
    abort_cond = 3'b000;
    lock_hit   = 1'b0;
    logged     = '0;
    for (int i = 0; i < NF; i++) begin
      logged[i] = rise[i] && fault_sev[i] != fault_supervisor_pkg::SEV_INFO
                  && fault_sev[i] != fault_supervisor_pkg::SEV_ALERT;
      unique case (fault_sev[i])
        fault_supervisor_pkg::SEV_ABORT0: begin
          abort_hit[0]  |= rise[i];
          abort_cond[0] |= fault_cond[i];
        end
        fault_supervisor_pkg::SEV_ABORT1: begin
          abort_hit[1]  |= rise[i];
          abort_cond[1] |= fault_cond[i];
        end
        fault_supervisor_pkg::SEV_ABORT2: begin
          abort_hit[2]  |= rise[i];
          abort_cond[2] |= fault_cond[i];
        end
        fault_supervisor_pkg::SEV_LOCKDOWN: lock_hit |= rise[i];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cond_prev_reg <= '0;
    end else begin
      cond_prev_reg <= fault_cond;
    end
  end

  // per-fault flags, counters and details
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_fault
      always_ff @(posedge clk) begin
        if (reset) begin
          active_reg[g]   <= 1'b0;
          occurred_reg[g] <= 1'b0;
          count_reg[g]    <= 16'h0000;
          limit_reg[g]    <= 16'h0000;
          value_reg[g]    <= 16'h0000;
          time_reg[g]     <= 32'h00000000;
        end else begin
          if (rise[g]) begin
            active_reg[g] <= 1'b1;
          end else if (fall[g]) begin
            active_reg[g] <= 1'b0;
          end
          if (rise[g]) begin
            occurred_reg[g] <= 1'b1;
          end else if (clear_hist) begin
            occurred_reg[g] <= 1'b0;
          end
          if (fall[g]) begin
            count_reg[g] <= clear_hist ? 16'h0001 : count_reg[g] + 16'h0001;
          end else if (clear_hist) begin
            count_reg[g] <= 16'h0000;
          end
          if (logged[g]) begin
            limit_reg[g] <= fault_data[g].limit;
            value_reg[g] <= fault_data[g].value;
            time_reg[g]  <= timestamp;
          end
        end
      end

      // per-fault checks, so every fault the scenarios raise is watched
      property p_occ_set;
        @(posedge clk) disable iff (reset) rise[g] |=> occurred_reg[g] && active_reg[g];
      endproperty
      a_occ_set: assert property (p_occ_set) else $error("fault not recorded");

      property p_fall_count;
        @(posedge clk) disable iff (reset)
          fall[g] && !clear_hist
          |=> count_reg[g] == $past(count_reg[g]) + 16'h0001 && !active_reg[g];
      endproperty
      a_fall_count: assert property (p_fall_count) else $error("fault count wrong");

      property p_log_keep;
        @(posedge clk) disable iff (reset)
          logged[g] |=> limit_reg[g] == $past(fault_data[g].limit)
          && value_reg[g] == $past(fault_data[g].value) && time_reg[g] == $past(timestamp);
      endproperty
      a_log_keep: assert property (p_log_keep) else $error("fault data not logged");

      property p_count_only;
        @(posedge clk) disable iff (reset)
          rise[g] && (fault_sev[g] == fault_supervisor_pkg::SEV_INFO
          || fault_sev[g] == fault_supervisor_pkg::SEV_ALERT) |=> $stable(limit_reg[g]);
      endproperty
      a_count_only: assert property (p_count_only) else $error("low fault was logged");
    end
  endgenerate

  // one-second prescaler
  always_ff @(posedge clk) begin
    if (reset || presc_reg == TICK_CYCLES - 1) begin
      presc_reg <= 32'h00000000;
    end else begin
      presc_reg <= presc_reg + 32'h00000001;
    end
  end
  assign tick = presc_reg == TICK_CYCLES - 1;

  // reconnect timers
  generate
    for (g = 0; g < 3; g++) begin : g_timer
      always_ff @(posedge clk) begin
        if (reset) begin
          tset_reg[g]  <= (g == 0) ? `FS_TSET0_RESET : `FS_TSET12_RESET;
          tstat_reg[g] <= 16'h0000;
          tbusy_reg[g] <= 1'b0;
        end else begin
          if (reg_req.wr && reg_req.addr == `FS_REG_TSET0 + 9'(g)) begin
            tset_reg[g] <= reg_req.wdata;
          end
          if (abort_hit[g] || (tbusy_reg[g] && abort_cond[g])) begin
            tstat_reg[g] <= tset_reg[g];
            tbusy_reg[g] <= 1'b1;
          end else if (tbusy_reg[g] && tick) begin
            if (tstat_reg[g] == 16'h0000) begin
              tbusy_reg[g] <= 1'b0;
            end else begin
              tstat_reg[g] <= tstat_reg[g] - 16'h0001;
            end
          end
        end
      end
    end
  endgenerate

  // lockdown latch; a new lockdown in the cycle of a service reset wins
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_reg <= 1'b0;
    end else if (lock_hit) begin
      lock_reg <= 1'b1;
    end else if (service_reset) begin
      lock_reg <= 1'b0;
    end
  end

  // converter run state
  always_ff @(posedge clk) begin
    if (reset) begin
      run_reg <= 1'b1;
    end else if (lock_hit || lock_reg || |abort_hit) begin
      run_reg <= 1'b0;
    end else if (!run_reg && tbusy_reg == 3'b000) begin
      if (!manual_mode || user_start) begin
        run_reg <= 1'b1;
      end
    end
  end
  assign power_converter_unit_run = run_reg;

  // register select
  always_ff @(posedge clk) begin
    if (reset) begin
      select_reg <= 6'h00;
    end else if (reg_req.wr && reg_req.addr == `FS_REG_SELECT) begin
      select_reg <= 6'(reg_req.wdata & `FS_SELECT_MASK);
    end
  end

  // read data
  logic [15:0] rd_next;
  logic [63:0] act_w;
  logic [63:0] occ_w;
  logic        sel_ok;
  assign act_w  = 64'(active_reg);
  assign occ_w  = 64'(occurred_reg);
  assign sel_ok = select_reg < 6'(NF);
  always_comb begin
    rd_next = 16'h0000;
    case (reg_req.addr)
      `FS_REG_SELECT:   rd_next = {10'h000, select_reg};
      `FS_REG_LIMIT:    rd_next = sel_ok ? limit_reg[select_reg] : 16'h0000;
      `FS_REG_VALUE:    rd_next = sel_ok ? value_reg[select_reg] : 16'h0000;
      `FS_REG_COUNT:    rd_next = sel_ok ? count_reg[select_reg] : 16'h0000;
      `FS_REG_TIME0:    rd_next = sel_ok ? time_reg[select_reg][15:0] : 16'h0000;
      `FS_REG_TIME1:    rd_next = sel_ok ? time_reg[select_reg][31:16] : 16'h0000;
      `FS_REG_SELECTOR: rd_next = {10'h000, select_reg};
      `FS_REG_STATUS:   rd_next = sel_ok ? {11'h000, occ_w[select_reg], act_w[select_reg],
                                            fault_sev[select_reg]} : 16'h0000;
      `FS_REG_ACTIVE0, `FS_REG_ACTIVE0 + 9'd1, `FS_REG_ACTIVE0 + 9'd2, `FS_REG_ACTIVE0 + 9'd3:
        rd_next = act_w[16*reg_req.addr[1:0] +: 16];
      `FS_REG_OCCUR0, `FS_REG_OCCUR0 + 9'd1, `FS_REG_OCCUR0 + 9'd2, `FS_REG_OCCUR0 + 9'd3:
        rd_next = occ_w[16*reg_req.addr[1:0] +: 16];
      `FS_REG_TSET0, `FS_REG_TSET0 + 9'd1, `FS_REG_TSET0 + 9'd2:
        rd_next = tset_reg[reg_req.addr[1:0]];
      `FS_REG_TSTAT0, `FS_REG_TSTAT0 + 9'd1, `FS_REG_TSTAT0 + 9'd2:
        rd_next = tstat_reg[reg_req.addr[1:0]];
      `FS_REG_SUMMARY: begin
        rd_next[`FS_SUM_ACTIVE_BIT] = |active_reg;
        rd_next[`FS_SUM_OCCUR_BIT]  = |occurred_reg;
        rd_next[`FS_SUM_COUNT_BIT]  = |tbusy_reg;
        rd_next[`FS_SUM_LOCK_BIT]   = lock_reg;
        rd_next[`FS_SUM_RUN_BIT]    = run_reg;
      end
      default: rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.rd) begin
      reg_rdata <= rd_next;
    end
  end

  // assertions
  property p_abort_stops;
    @(posedge clk) disable iff (reset) (|abort_hit) |=> !power_converter_unit_run;
  endproperty
  a_abort_stops: assert property (p_abort_stops) else $error("abort did not stop");

  property p_timer_load;
    @(posedge clk) disable iff (reset) abort_hit[0] |=> tbusy_reg[0] && tstat_reg[0] == $past(tset_reg[0]);
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("timer 0 not loaded");

  property p_no_run_counting;
    @(posedge clk) disable iff (reset) (|tbusy_reg) && !power_converter_unit_run |=> !power_converter_unit_run;
  endproperty
  a_no_run_counting: assert property (p_no_run_counting) else $error("resumed during countdown");

  property p_lock_holds;
    @(posedge clk) disable iff (reset) lock_reg && !service_reset |=> !power_converter_unit_run;
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("ran during lockdown");

  property p_manual_wait;
    @(posedge clk) disable iff (reset)
      manual_mode && !user_start && !power_converter_unit_run |=> !power_converter_unit_run;
  endproperty
  a_manual_wait: assert property (p_manual_wait) else $error("manual restart without start");

  property p_clear_occ;
    @(posedge clk) disable iff (reset) clear_hist && rise == '0 |=> occurred_reg == '0;
  endproperty
  a_clear_occ: assert property (p_clear_occ) else $error("history not cleared");

  property p_lock_stops;
    @(posedge clk) disable iff (reset) lock_hit |=> lock_reg && !power_converter_unit_run;
  endproperty
  a_lock_stops: assert property (p_lock_stops) else $error("lockdown did not stop");

  property p_timer_hold;
    @(posedge clk) disable iff (reset)
      tbusy_reg[0] && abort_cond[0] |=> tbusy_reg[0] && tstat_reg[0] == $past(tset_reg[0]);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("persisting fault let timer run");

  property p_timer_step;
    @(posedge clk) disable iff (reset)
      tbusy_reg[1] && tick && tstat_reg[1] != 16'h0000 && !abort_cond[1]
      |=> tstat_reg[1] == $past(tstat_reg[1]) - 16'h0001;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer 1 did not step");

  property p_timer_done;
    @(posedge clk) disable iff (reset)
      tbusy_reg[2] && tick && tstat_reg[2] == 16'h0000 && !abort_cond[2] |=> !tbusy_reg[2];
  endproperty
  a_timer_done: assert property (p_timer_done) else $error("timer 2 did not end");

  property p_select_mask;
    @(posedge clk) disable iff (reset)
      reg_req.wr && reg_req.addr == `FS_REG_SELECT |=> select_reg == $past(reg_req.wdata[5:0]);
  endproperty
  a_select_mask: assert property (p_select_mask) else $error("select not taken");

  property p_summary_read;
    @(posedge clk) disable iff (reset)
      reg_req.rd && reg_req.addr == `FS_REG_SUMMARY
      |=> reg_rdata[`FS_SUM_RUN_BIT] == $past(run_reg)
      && reg_rdata[`FS_SUM_LOCK_BIT] == $past(lock_reg);
  endproperty
  a_summary_read: assert property (p_summary_read) else $error("summary read wrong");

  property p_auto_resume;
    @(posedge clk) disable iff (reset)
      !power_converter_unit_run && tbusy_reg == 3'b000 && !lock_reg && !manual_mode
      && abort_hit == 3'b000 && !lock_hit |=> power_converter_unit_run;
  endproperty
  a_auto_resume: assert property (p_auto_resume) else $error("no auto resume");

  c_abort:   cover property (@(posedge clk) disable iff (reset) abort_hit[1]);
  c_resume:  cover property (@(posedge clk) disable iff (reset) $rose(power_converter_unit_run));
  c_lock:    cover property (@(posedge clk) disable iff (reset) $rose(lock_reg));
  c_manual:  cover property (@(posedge clk) disable iff (reset)
                             manual_mode && user_start && !power_converter_unit_run);

endmodule : fault_supervisor_reconnect

// [fault_supervisor_params.svh]
// constants for the fault supervisor: register indices, reset values, timing
// assumes a 20 MHz system clock and 16-bit holding registers
`ifndef FAULT_SUPERVISOR_PARAMS_SVH
`define FAULT_SUPERVISOR_PARAMS_SVH
`define FS_NUM_FAULTS      54
`define FS_REG_SELECT      9'd0
`define FS_REG_LIMIT       9'd1
`define FS_REG_VALUE       9'd2
`define FS_REG_COUNT       9'd3
`define FS_REG_TIME0       9'd4
`define FS_REG_TIME1       9'd5
`define FS_REG_SELECTOR    9'd8
`define FS_REG_STATUS      9'd9
`define FS_REG_CLEAR       9'd12
`define FS_REG_ACTIVE0     9'd16
`define FS_REG_OCCUR0      9'd24
`define FS_REG_TSET0       9'd256
`define FS_REG_TSTAT0      9'd288
`define FS_REG_SUMMARY     9'd298
`define FS_SELECT_MASK     16'h003F
`define FS_TSET0_RESET     16'h0140
`define FS_TSET12_RESET    16'h0014
`define FS_CLK_HZ          20000000
`define FS_TICK_S          1
`define FS_SUM_ACTIVE_BIT  0
`define FS_SUM_OCCUR_BIT   1
`define FS_SUM_COUNT_BIT   2
`define FS_SUM_LOCK_BIT    3
`define FS_SUM_RUN_BIT     4
`endif

// [fault_supervisor_pkg.sv]
// types shared by the fault supervisor
// assumes fault_supervisor_params.svh holds all numeric constants
package fault_supervisor_pkg;
  typedef enum logic [2:0] {
    SEV_INFO, SEV_ALERT, SEV_ALARM, SEV_ABORT0, SEV_ABORT1, SEV_ABORT2, SEV_LOCKDOWN
  } severity_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [8:0]  addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [15:0] limit;
    logic [15:0] value;
  } fault_data_s;
endpackage : fault_supervisor_pkg

// [site_ctrl.sv]
// site controller model: issues holding-register reads and writes
// assumes one-cycle wr/rd strobes taken at the rising clk edge
`timescale 1ns/100ps
module site_ctrl (
  // clock
  input  wire logic                      clk,
  // register port
  output fault_supervisor_pkg::reg_req_s req
);
  initial req = '0;
  // idle address and data lines show the inverse of the last value
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [8:0] a);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, 16'hFFFF};
  endtask : rd
endmodule : site_ctrl

// [tb.sv]
// self-checking bench for the fault supervisor
// assumes site_ctrl drives the register port
`timescale 1ns/100ps
`include "fault_supervisor_params.svh"
module tb;
  localparam int unsigned TICK = 10;
  logic                              clk = 1'b0;
  logic                              reset = 1'b1;
  logic [`FS_NUM_FAULTS-1:0]         cond = '0;
  fault_supervisor_pkg::severity_e   sev [`FS_NUM_FAULTS];
  fault_supervisor_pkg::fault_data_s fdat [`FS_NUM_FAULTS];
  logic [31:0]                       tstamp = '0;
  logic                              manual = 1'b0;
  logic                              ustart = 1'b0;
  logic                              sreset = 1'b0;
  fault_supervisor_pkg::reg_req_s    req;
  logic [15:0]                       rdata;
  logic                              run;
  logic                              rd_d = 1'b0;
  logic [15:0]                       expq [$];
  int                                fails = 0;
  int                                comparisons = 0;
  int                                seed = 32'haba9;

  always #25 clk = ~clk;

  site_ctrl i_ctrl (.clk(clk), .req(req));
  fault_supervisor_reconnect #(.TICK_CYCLES(TICK)) i_dut (
    .clk(clk), .reset(reset), .fault_cond(cond), .fault_sev(sev), .fault_data(fdat),
    .timestamp(tstamp), .manual_mode(manual), .user_start(ustart),
    .service_reset(sreset), .reg_req(req), .reg_rdata(rdata),
    .power_converter_unit_run(run));

  task automatic bad(input string m);
    fails++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : bad

  task automatic tally_and_finish;
    repeat (3) @(posedge clk);
    if (expq.size() != 0) bad("reads left unanswered");
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // read data appears one cycle after the strobe is taken
  always @(posedge clk) begin
    rd_d <= req.rd;
    if (rd_d) begin
      comparisons++;
      if (expq.size() == 0 || rdata !== expq[0]) bad("read data mismatch");
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end

  task automatic chk(input logic [8:0] a, input logic [15:0] e);
    expq.push_back(e);
    i_ctrl.rd(a);
  endtask : chk

  // bounded wait for a run level, or hold n cycles then look
  task automatic see_run(input logic e, input int n, input bit hold);
    // look between edges, where the registered run level has settled
    for (int k = 0; k < n && (hold || run !== e); k++) @(negedge clk);
    comparisons++;
    if (run !== e) bad("converter run level");
  endtask : see_run

  task automatic fault(input int id, input fault_supervisor_pkg::severity_e s, input int n);
    @(posedge clk);
    sev[id] <= s;
    fdat[id] <= '{limit: 16'($random(seed)), value: 16'($random(seed))};
    tstamp <= $random(seed);
    @(posedge clk);
    cond[id] <= 1'b1;
    repeat (n) @(posedge clk);
    cond[id] <= 1'b0;
  endtask : fault

  initial begin
    foreach (sev[i]) sev[i] = fault_supervisor_pkg::SEV_INFO;
    foreach (fdat[i]) fdat[i] = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    chk(`FS_REG_TSET0, 16'h0140);
    chk(`FS_REG_TSET0 + 9'd1, 16'h0014);
    chk(`FS_REG_TSET0 + 9'd2, 16'h0014);
    chk(`FS_REG_SUMMARY, 16'h0010);
    chk(9'd100, 16'h0000);
    i_ctrl.wr(`FS_REG_TSET0, 16'h0003);
    i_ctrl.wr(`FS_REG_TSET0 + 9'd1, 16'h0002);
    i_ctrl.wr(`FS_REG_TSET0 + 9'd2, 16'h0002);
    chk(`FS_REG_TSET0, 16'h0003);
    fork
      fault(3, fault_supervisor_pkg::SEV_ABORT0, 60);
      begin
        repeat (10) @(posedge clk);
        see_run(1'b0, 1, 1);
        chk(`FS_REG_SUMMARY, 16'h0007);
        chk(`FS_REG_ACTIVE0, 16'h0008);
        chk(`FS_REG_TSTAT0, 16'h0003);
      end
    join
    see_run(1'b0, 15, 1);
    see_run(1'b1, 60, 0);
    chk(`FS_REG_TSTAT0, 16'h0000);
    i_ctrl.wr(`FS_REG_SELECT, 16'hFFC3);
    chk(`FS_REG_SELECT, 16'h0003);
    chk(`FS_REG_LIMIT, fdat[3].limit);
    chk(`FS_REG_VALUE, fdat[3].value);
    chk(`FS_REG_COUNT, 16'h0001);
    chk(`FS_REG_TIME0, tstamp[15:0]);
    chk(`FS_REG_TIME1, tstamp[31:16]);
    chk(`FS_REG_SELECTOR, 16'h0003);
    chk(`FS_REG_STATUS, 16'h0013);
    fork
      fault(20, fault_supervisor_pkg::SEV_ALARM, 20);
      begin
        repeat (4) @(posedge clk);
        chk(`FS_REG_ACTIVE0 + 9'd1, 16'h0010);
      end
    join
    for (int s = 0; s < 7; s++) begin
      fault(10 + s, fault_supervisor_pkg::severity_e'(s), 2);
      see_run(s < 3, 3, 1);
      if (s == 6) begin
        see_run(1'b0, 60, 1);
        @(posedge clk);
        sreset <= 1'b1;
        @(posedge clk);
        sreset <= 1'b0;
      end
      see_run(1'b1, 80, 0);
    end
    chk(`FS_REG_OCCUR0, 16'hFC08);
    chk(`FS_REG_OCCUR0 + 9'd1, 16'h0011);
    @(posedge clk);
    manual <= 1'b1;
    fault(30, fault_supervisor_pkg::SEV_ABORT1, 2);
    see_run(1'b0, 60, 1);
    @(posedge clk);
    ustart <= 1'b1;
    @(posedge clk);
    ustart <= 1'b0;
    manual <= 1'b0;
    see_run(1'b1, 5, 0);
    i_ctrl.wr(`FS_REG_CLEAR, 16'h0001);
    chk(`FS_REG_OCCUR0, 16'h0000);
    chk(`FS_REG_OCCUR0 + 9'd1, 16'h0000);
    chk(`FS_REG_COUNT, 16'h0000);
    chk(`FS_REG_CLEAR, 16'h0000);
    @(posedge clk);
    sev[40] <= fault_supervisor_pkg::SEV_INFO;
    sev[41] <= fault_supervisor_pkg::SEV_ABORT2;
    @(posedge clk);
    cond[41:40] <= 2'b11;
    @(posedge clk);
    cond[41:40] <= 2'b00;
    see_run(1'b0, 3, 1);
    chk(`FS_REG_OCCUR0 + 9'd2, 16'h0300);
    see_run(1'b1, 80, 0);
    tally_and_finish();
  end

  initial begin
    #(20000 * 50);
    bad("watchdog expired");
    tally_and_finish();
  end
endmodule : tb
